/* File: bench/cmb_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none
// protocol engine side: receive frames and transmit fetches
module cmb_engine_model (
  input wire logic pclk,
  output logic rx_id_start,
  output logic rx_done,
  output logic [28:0] rx_id,
  output logic rx_ide,
  output logic rx_srr,
  output logic rx_rtr,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data,
  input wire logic rx_stored,
  input wire logic [3:0] rx_slot,
  output logic tx_load,
  output logic [3:0] tx_slot
);
  initial begin
    {rx_id_start, rx_done, rx_id, rx_ide, rx_srr, rx_rtr} = '0;
    {rx_dlc, rx_data, tx_load, tx_slot} = '0;
  end
  // one frame; got is 5'h10 when nothing was stored
  task automatic frame(input logic [28:0] id, input logic ide,
      input logic [3:0] dlc, input logic [63:0] d, output logic [4:0] got);
    got = 5'h10;
    @(posedge pclk);
    rx_id_start <= 1'b1;
    @(posedge pclk);
    rx_id_start <= 1'b0;
    repeat (2) @(posedge pclk);
    rx_id <= id;
    rx_ide <= ide;
    rx_srr <= ide;
    rx_rtr <= 1'b0;
    rx_dlc <= dlc;
    rx_data <= d;
    rx_done <= 1'b1;
    @(posedge pclk);
    rx_done <= 1'b0;
    rx_id <= ~id;
    rx_data <= ~d;
    rx_dlc <= ~dlc;
    repeat (5) begin
      @(posedge pclk);
      if (rx_stored === 1'b1) got = {1'b0, rx_slot};
    end
  endtask
  task automatic load(input logic [3:0] s);
    @(posedge pclk);
    tx_load <= 1'b1;
    tx_slot <= s;
    @(posedge pclk);
    tx_load <= 1'b0;
    tx_slot <= ~s;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rx_id_start, rx_done, rx_ide, rx_srr, rx_rtr, rx_stored;
  logic [28:0] rx_id, tx_id;
  logic [3:0] rx_dlc, rx_slot, tx_slot, tx_dlc, tx_bytes;
  logic [63:0] rx_data, tx_data;
  logic tx_load, tx_valid, tx_ide, tx_rtr;
  int n_mismatch = 0;
  int num_checks = 0;
  localparam logic [28:0] SID = 29'h0AB4_0000;
  localparam logic [28:0] XID = 29'h1ABC_DEF1;
  localparam logic [63:0] DAT = 64'h0123_4567_89AB_CDEF;
  localparam logic [31:0] CMASK = 32'h0F0F_0000;
  cmb_slots u_cmb_slots (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_id_start(rx_id_start), .rx_done(rx_done), .rx_id(rx_id),
    .rx_ide(rx_ide), .rx_srr(rx_srr), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
    .rx_data(rx_data), .rx_stored(rx_stored), .rx_slot(rx_slot),
    .tx_load(tx_load), .tx_slot(tx_slot), .tx_valid(tx_valid),
    .tx_id(tx_id), .tx_ide(tx_ide), .tx_rtr(tx_rtr), .tx_dlc(tx_dlc),
    .tx_bytes(tx_bytes), .tx_data(tx_data));
  cmb_engine_model u_cmb_engine_model (.pclk(pclk),
    .rx_id_start(rx_id_start), .rx_done(rx_done), .rx_id(rx_id),
    .rx_ide(rx_ide), .rx_srr(rx_srr), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
    .rx_data(rx_data), .rx_stored(rx_stored), .rx_slot(rx_slot),
    .tx_load(tx_load), .tx_slot(tx_slot));
  always #12.5 pclk = ~pclk;
  function automatic logic [31:0] cs(logic [3:0] c, logic ide, logic rtr,
      logic [3:0] len);
    return {4'h0, c, 2'b00, ide, rtr, len, 16'h0000};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdm(input string nm, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, x, r & m)
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rdm("reset cs", 8'h50, 32'hFFFF_FFFF, 32'h0);
    apb(1'b0, 8'h02, 32'h0, r, e);
    `CHK("unaligned err", 1'b1, e)
    wr(8'h64, 32'hFFFF_FFFF);
    rdm("id reserved", 8'h64, 32'hFFFF_FFFF, 32'h1FFF_FFFF);
  endtask
  task automatic rx_step(input logic [3:0] dlc, input logic rd,
      input logic [3:0] code);
    logic [4:0] g;
    u_cmb_engine_model.frame(SID | 29'h155, 1'b0, dlc, DAT, g);
    `CHK("rx slot", 5'h01, g)
    if (rd) rdm("rx cs", 8'h10, CMASK,
        {4'h0, code, 4'h0, dlc, 16'h0});
  endtask
  task automatic t_rx();
    wr(8'h04, {3'b000, SID});
    wr(8'h14, {3'b000, SID});
    wr(8'h10, cs(cmb_pkg::CODE_EMPTY, 1'b0, 1'b0, 4'h0));
    rx_step(4'h8, 1'b1, cmb_pkg::CODE_FULL);
    rdm("rx lo", 8'h18, 32'hFFFF_FFFF, DAT[63:32]);
    rdm("rx hi", 8'h1C, 32'hFFFF_FFFF, DAT[31:0]);
    rdm("rx id", 8'h14, 32'hFFFF_FFFF, {3'b000, SID});
    rx_step(4'h3, 1'b0, 4'h0);
    rx_step(4'h3, 1'b1, cmb_pkg::CODE_OVERRUN);
    rx_step(4'h5, 1'b0, 4'h0);
    rx_step(4'h6, 1'b0, 4'h0);
    rx_step(4'h7, 1'b1, cmb_pkg::CODE_OVERRUN);
    rx_step(4'h1, 1'b1, cmb_pkg::CODE_FULL);
    rx_step(4'h2, 1'b1, cmb_pkg::CODE_FULL);
  endtask
  task automatic t_ext();
    logic [4:0] g;
    wr(8'h24, {3'b000, XID});
    wr(8'h20, cs(cmb_pkg::CODE_EMPTY, 1'b1, 1'b0, 4'h0));
    u_cmb_engine_model.frame(XID ^ 29'h1, 1'b1, 4'h4, DAT, g);
    `CHK("ext miss", 5'h10, g)
    u_cmb_engine_model.frame(XID, 1'b1, 4'h4, DAT, g);
    `CHK("ext hit", 5'h02, g)
    rdm("ext cs", 8'h20, 32'h007F_0000, 32'h0064_0000);
  endtask
  task automatic t_tx();
    wr(8'h34, {3'b000, SID | 29'h3FF});
    wr(8'h38, 32'hA1B2_C3D4);
    wr(8'h3C, 32'h1122_3344);
    wr(8'h30, cs(4'hC, 1'b0, 1'b0, 4'h5));
    u_cmb_engine_model.load(4'h3);
    #1;
    `CHK("tx valid", 1'b1, tx_valid)
    `CHK("tx dlc", 4'h5, tx_dlc)
    `CHK("tx bytes", 4'h5, tx_bytes)
    `CHK("tx id std", SID, tx_id)
    `CHK("tx data", 64'hA1B2_C3D4_1122_3344, tx_data)
    rdm("tx code", 8'h30, 32'h0E00_0000, 32'h0C00_0000);
    wr(8'h30, cs(4'hC, 1'b0, 1'b1, 4'h8));
    u_cmb_engine_model.load(4'h3);
    #1;
    `CHK("rtr bytes", 4'h0, tx_bytes)
    `CHK("rtr dlc", 4'h8, tx_dlc)
    `CHK("rtr flag", 1'b1, tx_rtr)
    wr(8'h30, cs(4'hC, 1'b0, 1'b0, 4'hF));
    u_cmb_engine_model.load(4'h3);
    #1;
    `CHK("clamp bytes", 4'h8, tx_bytes)
    `CHK("clamp dlc", 4'hF, tx_dlc)
    u_cmb_engine_model.load(4'h2);
    #1;
    `CHK("tx id ext", XID, tx_id)
    `CHK("tx ide", 1'b1, tx_ide)
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rx();
    t_ext();
    t_tx();
    wrap_up();
  end
  initial begin
    #(25 * 20000);
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire

/* File: common/cmb_pkg.sv */
`default_nettype none
package cmb_pkg;
  // slot layout, byte offsets and word indexes inside one slot
  localparam int SLOT_BYTES = 16;
  localparam int WORDS_PER_SLOT = 4;
  localparam logic [3:0] OFF_CS = 4'h0;
  localparam logic [3:0] OFF_ID = 4'h4;
  localparam logic [3:0] OFF_DATA_LO = 4'h8;
  localparam logic [3:0] OFF_DATA_HI = 4'hC;
  localparam logic [1:0] WORD_CS = 2'h0;
  localparam logic [1:0] WORD_ID = 2'h1;
  localparam logic [1:0] WORD_DLO = 2'h2;
  localparam logic [1:0] WORD_DHI = 2'h3;
  // control/status field positions
  localparam int CODE_HI = 27;
  localparam int CODE_LO = 24;
  localparam int SRR_BIT = 22;
  localparam int IDE_BIT = 21;
  localparam int RTR_BIT = 20;
  localparam int LEN_HI = 19;
  localparam int LEN_LO = 16;
  localparam int TS_HI = 15;
  localparam int TS_LO = 0;
  // identifier layout
  localparam int ID_W = 29;
  localparam logic [28:0] STD_ID_MASK = 29'h1FFC_0000;
  // writable bits, reserved bits read as zero
  localparam logic [31:0] CS_WMASK = 32'h0F7F_FFFF;
  localparam logic [31:0] ID_WMASK = 32'h1FFF_FFFF;
  // receive codes, byte counts and store states
  localparam logic [3:0] CODE_INACTIVE = 4'h0;
  localparam logic [3:0] CODE_EMPTY = 4'h4;
  localparam logic [3:0] CODE_FULL = 4'h2;
  localparam logic [3:0] CODE_OVERRUN = 4'h6;
  localparam logic [3:0] CODE_BUSY_EMPTY = 4'h3;
  localparam logic [3:0] CODE_BUSY_OVER = 4'h7;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  localparam logic [3:0] NO_BYTES = 4'h0;
  typedef enum logic [1:0] {
    CMB_IDLE = 2'b00,
    CMB_MARK = 2'b01,
    CMB_FILL = 2'b11
  } cmb_state_t;
endpackage
`default_nettype wire

/* File: logic/cmb_slots.sv */
`timescale 1ns/100ps
`default_nettype none
module cmb_slots #(
  parameter int SLOTS = 16,
  parameter int ADDR_W = 8,
  parameter int SLOT_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_id_start,
  input wire logic rx_done,
  input wire logic [28:0] rx_id,
  input wire logic rx_ide,
  input wire logic rx_srr,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  output logic rx_stored,
  output logic [SLOT_W-1:0] rx_slot,
  input wire logic tx_load,
  input wire logic [SLOT_W-1:0] tx_slot,
  output logic tx_valid,
  output logic [28:0] tx_id,
  output logic tx_ide,
  output logic tx_rtr,
  output logic [3:0] tx_dlc,
  output logic [3:0] tx_bytes,
  output logic [63:0] tx_data
);
  localparam int WORDS = SLOTS * cmb_pkg::WORDS_PER_SLOT;
  localparam int WIDX_W = SLOT_W + 2;
  localparam int MAP_BYTES = SLOTS * cmb_pkg::SLOT_BYTES;

  function automatic logic id_match(input logic [28:0] a,
                                    input logic a_ext,
                                    input logic [28:0] b,
                                    input logic b_ext);
    logic [28:0] m;
    m = a_ext ? {cmb_pkg::ID_W{1'b1}} : cmb_pkg::STD_ID_MASK;
    id_match = (a_ext == b_ext) && ((a & m) == (b & m));
  endfunction

  function automatic logic [WIDX_W-1:0] widx(input logic [SLOT_W-1:0] s,
                                             input logic [1:0] w);
    widx = {s, w};
  endfunction

  logic [31:0] mem_q [WORDS];
  logic [SLOTS-1:0] seen_q;
  logic [15:0] timer_q;
  logic [15:0] ts_hold_q;
  cmb_pkg::cmb_state_t state_q;
  logic [SLOT_W-1:0] tgt_q;
  logic over_q;
  logic [28:0] f_id_q;
  logic f_ide_q;
  logic f_srr_q;
  logic f_rtr_q;
  logic [3:0] f_dlc_q;
  logic [63:0] f_data_q;
  logic [15:0] f_ts_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic rx_stored_q;
  logic [SLOT_W-1:0] rx_slot_q;
  logic tx_valid_q;
  logic [28:0] tx_id_q;
  logic tx_ide_q;
  logic tx_rtr_q;
  logic [3:0] tx_dlc_q;
  logic [3:0] tx_bytes_q;
  logic [63:0] tx_data_q;

  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire bad_addr = (32'(paddr) >= 32'(MAP_BYTES)) || (paddr[1:0] != 2'h0);
  wire [WIDX_W-1:0] cpu_idx = paddr[WIDX_W+1:2];
  wire [1:0] cpu_word = paddr[3:2];
  wire [SLOT_W-1:0] cpu_slot = paddr[WIDX_W+1:4];
  wire cpu_wr = access && pwrite && !bad_addr;
  wire cpu_cs_rd = access && !pwrite && !bad_addr
                   && (cpu_word == cmb_pkg::WORD_CS);
  wire cpu_cs_wr = cpu_wr && (cpu_word == cmb_pkg::WORD_CS);
  wire [31:0] wmask = (cpu_word == cmb_pkg::WORD_CS) ? cmb_pkg::CS_WMASK :
                      (cpu_word == cmb_pkg::WORD_ID) ? cmb_pkg::ID_WMASK :
                      '1;
  wire [31:0] rd_word = bad_addr ? '0 : mem_q[cpu_idx];

  // matching: lowest active slot with equal identifier wins
  logic hit;
  logic [SLOT_W-1:0] hit_idx;
  always_comb begin
    logic [3:0] c;
    logic [31:0] cs;
    c = '0;
    cs = '0;
    hit = 1'b0;
    hit_idx = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      cs = mem_q[widx(SLOT_W'(i), cmb_pkg::WORD_CS)];
      c = cs[cmb_pkg::CODE_HI:cmb_pkg::CODE_LO];
      if ((c == cmb_pkg::CODE_EMPTY || c == cmb_pkg::CODE_FULL ||
           c == cmb_pkg::CODE_OVERRUN) &&
          id_match(mem_q[widx(SLOT_W'(i), cmb_pkg::WORD_ID)][28:0],
                   cs[cmb_pkg::IDE_BIT], rx_id, rx_ide)) begin
        hit = 1'b1;
        hit_idx = SLOT_W'(i);
      end
    end
  end

  wire [31:0] hit_cs = mem_q[widx(hit_idx, cmb_pkg::WORD_CS)];
  wire [3:0] hit_code = hit_cs[cmb_pkg::CODE_HI:cmb_pkg::CODE_LO];
  // unread full or overrun slot gets overwritten into overrun
  wire hit_over = (hit_code != cmb_pkg::CODE_EMPTY) && !seen_q[hit_idx];
  wire take = (state_q == cmb_pkg::CMB_IDLE) && rx_done && hit;
  wire [3:0] busy_code = over_q ? cmb_pkg::CODE_BUSY_OVER :
                         cmb_pkg::CODE_BUSY_EMPTY;
  wire [3:0] final_code = over_q ? cmb_pkg::CODE_OVERRUN :
                          cmb_pkg::CODE_FULL;
  wire [31:0] fill_cs = {4'h0, final_code, 1'b0, f_srr_q, f_ide_q, f_rtr_q,
                         f_dlc_q, f_ts_q};
  wire [31:0] tx_cs = mem_q[widx(tx_slot, cmb_pkg::WORD_CS)];
  wire [28:0] tx_raw_id = mem_q[widx(tx_slot, cmb_pkg::WORD_ID)][28:0];
  wire [3:0] tx_len = tx_cs[cmb_pkg::LEN_HI:cmb_pkg::LEN_LO];
  wire tx_len_big = tx_len > cmb_pkg::MAX_BYTES;

  // free-running timer and time stamp capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= '0;
      ts_hold_q <= '0;
    end else begin
      timer_q <= timer_q + 16'h0001;
      if (rx_id_start) begin
        ts_hold_q <= timer_q;
      end
    end
  end

  // receive store sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cmb_pkg::CMB_IDLE;
      tgt_q <= '0;
      over_q <= 1'b0;
      f_id_q <= '0;
      f_ide_q <= 1'b0;
      f_srr_q <= 1'b0;
      f_rtr_q <= 1'b0;
      f_dlc_q <= '0;
      f_data_q <= '0;
      f_ts_q <= '0;
      rx_stored_q <= 1'b0;
      rx_slot_q <= '0;
    end else begin
      rx_stored_q <= 1'b0;
      unique case (state_q)
        cmb_pkg::CMB_IDLE: begin
          if (take) begin
            state_q <= cmb_pkg::CMB_MARK;
            tgt_q <= hit_idx;
            over_q <= hit_over;
            f_id_q <= rx_ide ? rx_id : (rx_id & cmb_pkg::STD_ID_MASK);
            f_ide_q <= rx_ide;
            f_srr_q <= rx_srr;
            f_rtr_q <= rx_rtr;
            f_dlc_q <= rx_dlc;
            f_data_q <= rx_data;
            f_ts_q <= ts_hold_q;
          end
        end
        cmb_pkg::CMB_MARK: state_q <= cmb_pkg::CMB_FILL;
        cmb_pkg::CMB_FILL: begin
          state_q <= cmb_pkg::CMB_IDLE;
          rx_stored_q <= 1'b1;
          rx_slot_q <= tgt_q;
        end
        default: state_q <= cmb_pkg::CMB_IDLE;
      endcase
    end
  end

  // slot memory, engine writes after cpu so the store wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      if (cpu_wr) begin
        mem_q[cpu_idx] <= pwdata & wmask;
      end
      if (state_q == cmb_pkg::CMB_MARK) begin
        mem_q[widx(tgt_q, cmb_pkg::WORD_CS)]
          [cmb_pkg::CODE_HI:cmb_pkg::CODE_LO] <= busy_code;
      end
      if (state_q == cmb_pkg::CMB_FILL) begin
        mem_q[widx(tgt_q, cmb_pkg::WORD_CS)] <= fill_cs;
        mem_q[widx(tgt_q, cmb_pkg::WORD_ID)] <= {3'h0, f_id_q};
        mem_q[widx(tgt_q, cmb_pkg::WORD_DLO)] <= f_data_q[63:32];
        mem_q[widx(tgt_q, cmb_pkg::WORD_DHI)] <= f_data_q[31:0];
      end
    end
  end

  // read-since-store marks, the store clear loses to a same-cycle read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= '0;
    end else begin
      if (state_q == cmb_pkg::CMB_FILL) begin
        seen_q[tgt_q] <= 1'b0;
      end
      if (cpu_cs_wr) begin
        seen_q[cpu_slot] <= 1'b0;
      end
      if (cpu_cs_rd) begin
        seen_q[cpu_slot] <= 1'b1;
      end
    end
  end

  // apb answer, one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? '0 : rd_word;
        pslverr_q <= bad_addr;
      end
    end
  end

  // transmit fetch for the protocol engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_q <= 1'b0;
      tx_id_q <= '0;
      tx_ide_q <= 1'b0;
      tx_rtr_q <= 1'b0;
      tx_dlc_q <= '0;
      tx_bytes_q <= '0;
      tx_data_q <= '0;
    end else begin
      tx_valid_q <= tx_load;
      if (tx_load) begin
        tx_id_q <= tx_cs[cmb_pkg::IDE_BIT] ? tx_raw_id :
                   (tx_raw_id & cmb_pkg::STD_ID_MASK);
        tx_ide_q <= tx_cs[cmb_pkg::IDE_BIT];
        tx_rtr_q <= tx_cs[cmb_pkg::RTR_BIT];
        tx_dlc_q <= tx_len;
        tx_bytes_q <= tx_cs[cmb_pkg::RTR_BIT] ? cmb_pkg::NO_BYTES :
                      tx_len_big ? cmb_pkg::MAX_BYTES : tx_len;
        tx_data_q <= {mem_q[widx(tx_slot, cmb_pkg::WORD_DLO)],
                      mem_q[widx(tx_slot, cmb_pkg::WORD_DHI)]};
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_stored = rx_stored_q;
  assign rx_slot = rx_slot_q;
  assign tx_valid = tx_valid_q;
  assign tx_id = tx_id_q;
  assign tx_ide = tx_ide_q;
  assign tx_rtr = tx_rtr_q;
  assign tx_dlc = tx_dlc_q;
  assign tx_bytes = tx_bytes_q;
  assign tx_data = tx_data_q;

  // checks
  wire [31:0] tgt_cs = mem_q[widx(tgt_q, cmb_pkg::WORD_CS)];
  wire [3:0] tgt_code = tgt_cs[cmb_pkg::CODE_HI:cmb_pkg::CODE_LO];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  busy_mark_a: assert property (
    state_q == cmb_pkg::CMB_MARK |=> tgt_code[0] && !tgt_code[3]
  ) else $error("busy code not shown during store");
  store_code_a: assert property (
    state_q == cmb_pkg::CMB_MARK && !over_q
    |=> ##1 tgt_code == cmb_pkg::CODE_FULL
  ) else $error("store into empty slot did not end full");
  over_code_a: assert property (
    state_q == cmb_pkg::CMB_MARK && over_q
    |=> ##1 tgt_code == cmb_pkg::CODE_OVERRUN
  ) else $error("overwrite did not end in overrun");
  take_seq_a: assert property (
    take |=> state_q == cmb_pkg::CMB_MARK ##1 state_q == cmb_pkg::CMB_FILL
    ##1 rx_stored
  ) else $error("store sequence broken");
  no_hit_a: assert property (
    state_q == cmb_pkg::CMB_IDLE && rx_done && !hit
    |=> state_q == cmb_pkg::CMB_IDLE
  ) else $error("frame stored without a matching active slot");
  ts_capture_a: assert property (
    rx_id_start |=> ts_hold_q == $past(timer_q)
  ) else $error("time stamp not captured at identifier start");
  remote_len_a: assert property (
    tx_load && tx_cs[cmb_pkg::RTR_BIT] |=> tx_bytes == cmb_pkg::NO_BYTES
  ) else $error("remote frame given data bytes");
  tx_dlc_a: assert property (
    tx_load |=> tx_dlc == $past(tx_len) && tx_valid
  ) else $error("outgoing length code differs from slot");
  std_id_a: assert property (
    tx_load && !tx_cs[cmb_pkg::IDE_BIT] |=> tx_id[17:0] == 18'h0
  ) else $error("standard frame carried low identifier bits");
  fill_len_a: assert property (
    take |=> ##2 tgt_cs[cmb_pkg::LEN_HI:cmb_pkg::LEN_LO] == $past(rx_dlc, 3)
  ) else $error("length field not taken from frame");
  apb_ready_a: assert property (
    setup |=> pready ##1 !pready
  ) else $error("apb answer timing wrong");

  store_empty_c: cover property (take && !hit_over);
  store_over_c: cover property (take && hit_over);
  tx_remote_c: cover property (tx_load && tx_cs[cmb_pkg::RTR_BIT]);
  apb_err_c: cover property (access && pslverr);
endmodule
`default_nettype wire
